/* File: common/rtc_port_pkg.sv */
// shared constants for the serial register port
package rtc_port_pkg;
  localparam logic [6:0]  DEV_ADDR      = 7'h68;   // 1101000
  localparam logic        DIR_READ      = 1'b1;
  localparam int          BYTE_BITS     = 8;
  localparam int          PTR_W         = 8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  // the clock falls once after a start before bit 7 is sent
  localparam logic [3:0]  BIT_PRE       = 4'hf;
  localparam logic [7:0]  PTR_RESET     = 8'h00;
  localparam int          REF_HZ        = 20_000_000;
  localparam int          SCL_HZ        = 100_000;
  // quarter period of the generated serial clock (one master step), rounded down
  localparam int          HALF_CYC      = REF_HZ / (2 * SCL_HZ);
  localparam logic [7:0]  HALF_CNT      = 8'(HALF_CYC - 1);
  localparam logic [7:0]  ZERO8         = 8'h00;
  localparam logic [3:0]  ZERO4         = 4'h0;
endpackage : rtc_port_pkg

/* File: common/i2c_link_if.sv */
// two-wire link between bus master and register port
`timescale 1ns/100ps
interface i2c_link_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // open drain: a line is low while any end drives low
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out));
  modport slave  (input scl, input sda, output sda_s_out, output sda_s_oe);
  modport master (input scl, input sda, output scl_out, output scl_oe,
                  output sda_m_out, output sda_m_oe);
endinterface : i2c_link_if

/* File: verilog/rtc_i2c_slave.sv */
// register port slave end of the two-wire link
// Function
// RULE1: acknowledge every byte once addressed
// RULE2: master adds ninth clock for acknowledge
// RULE3: acknowledger holds data low through clock high
// RULE4: master acks all read bytes but last
// RULE5: on not-acknowledge stop sending, release data
// RULE6: bytes shift most significant bit first
// RULE7: address 1101000 matched, direction zero writes
// RULE8: direction one: ack, then send from pointer
// RULE9: first written byte loads register pointer
// RULE10: pointer advances after every data byte
// RULE11: master sends any data bytes, then stop
// RULE12: pointer kept between transfers
// RULE13: repeated start restarts address phase
// RULE14: start begins transfer, stop ends it
// RULE15: master makes all clocks, starts, stops
// RULE16: start is data falling while clock high
// RULE17: stop is data rising while clock high
// RULE18: data changes only while clock low
// RULE19: address mismatch: release, ignore until start
`timescale 1ns/100ps
module rtc_i2c_slave
(
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst_b,
  // link
  i2c_link_if.slave                        link,
  // register space
  output logic [rtc_port_pkg::PTR_W-1:0]   reg_addr,
  output logic [7:0]                       reg_wdata,
  output logic                             reg_we,
  input  wire logic [7:0]                  reg_rdata
);
  import rtc_port_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR  = 3'b010,
    ST_WR   = 3'b011,
    ST_RD   = 3'b100
  } phase_e;

  typedef struct packed
  {
    logic       scl_m;      // synchroniser first stages
    logic       sda_m;
    logic       scl_s;      // synchronised levels
    logic       sda_s;
    logic       scl_d;      // previous levels for edges
    logic       sda_d;
    phase_e     phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       ack_slot;   // ninth slot is ours to drive low
    logic       rd_ack;     // master answered read byte with ack
    logic       sda_low;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic       we;
  } state_s;

  state_s state_ff;
  state_s nxt_state;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // ----------------------------------------
  // bus conditions
  // ----------------------------------------
  // edges seen only on synchronised copies, never on first stage
  assign scl_rise  = state_ff.scl_s & ~state_ff.scl_d;
  assign scl_fall  = ~state_ff.scl_s & state_ff.scl_d;
  assign start_det = state_ff.scl_s & state_ff.scl_d &
                     state_ff.sda_d & ~state_ff.sda_s;   // RULE16
  assign stop_det  = state_ff.scl_s & state_ff.scl_d &
                     ~state_ff.sda_d & state_ff.sda_s;   // RULE17

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.scl_m = link.scl;
    nxt_state.sda_m = link.sda;
    nxt_state.scl_s = state_ff.scl_m;
    nxt_state.sda_s = state_ff.sda_m;
    nxt_state.scl_d = state_ff.scl_s;
    nxt_state.sda_d = state_ff.sda_s;
    nxt_state.we    = 1'b0;
    if (start_det)
    begin
      // repeated start too: back to address phase, pointer kept
      nxt_state.phase    = ST_ADDR;   // RULE13 RULE14
      // counter wraps to zero on the fall that follows the start
      nxt_state.bit_cnt  = BIT_PRE;
      nxt_state.ack_slot = 1'b0;
      nxt_state.sda_low  = 1'b0;
    end
    else if (stop_det)
    begin
      nxt_state.phase   = ST_IDLE;    // RULE14 RULE12
      nxt_state.sda_low = 1'b0;
    end
    else if (state_ff.phase != ST_IDLE)
    begin
      // data sampled on rising clock edge
      if (scl_rise)
      begin
        if (state_ff.bit_cnt == BIT_ACK)
          nxt_state.rd_ack = ~state_ff.sda_s;
        else if (state_ff.phase != ST_RD)
          nxt_state.shift = {state_ff.shift[6:0], state_ff.sda_s}; // RULE6
      end
      // all drive changes at falling edge, while clock is low
      if (scl_fall)
      begin
        nxt_state.sda_low = 1'b0;                          // RULE18
        if (state_ff.bit_cnt == BIT_LAST)
        begin
          nxt_state.bit_cnt = BIT_ACK;
          case (state_ff.phase)
            ST_ADDR:
            begin
              if (state_ff.shift[7:1] == DEV_ADDR)         // RULE7
              begin
                nxt_state.ack_slot = 1'b1;
                nxt_state.sda_low  = 1'b1;                 // RULE1 RULE3
              end
              else
                nxt_state.phase = ST_IDLE;                 // RULE19
            end
            ST_PTR, ST_WR:
            begin
              nxt_state.ack_slot = 1'b1;
              nxt_state.sda_low  = 1'b1;                   // RULE1
            end
            ST_RD:
            begin
              nxt_state.ack_slot = 1'b0;   // master answers here
              nxt_state.ptr      = state_ff.ptr + 8'h01;   // RULE10
            end
            default:
              nxt_state.phase = ST_IDLE;
          endcase
        end
        else if (state_ff.bit_cnt == BIT_ACK)
        begin
          nxt_state.bit_cnt  = ZERO4;
          nxt_state.ack_slot = 1'b0;
          case (state_ff.phase)
            ST_ADDR:
            begin
              // direction acted on only once our address ack is over
              if (state_ff.shift[0] == DIR_READ)
              begin
                nxt_state.phase   = ST_RD;                 // RULE8
                nxt_state.shift   = reg_rdata;
                nxt_state.sda_low = ~reg_rdata[7];         // RULE6
              end
              else
                nxt_state.phase = ST_PTR;                  // RULE7
            end
            ST_PTR:
            begin
              nxt_state.ptr   = state_ff.shift;            // RULE9
              nxt_state.phase = ST_WR;
            end
            ST_WR:
            begin
              nxt_state.wdata = state_ff.shift;
              nxt_state.we    = 1'b1;
              nxt_state.ptr   = state_ff.ptr + 8'h01;      // RULE10
            end
            ST_RD:
            begin
              // master acked the byte: fetch the next one
              if (state_ff.rd_ack)                         // RULE4
              begin
                nxt_state.shift   = reg_rdata;             // RULE8 RULE10
                nxt_state.sda_low = ~reg_rdata[7];         // RULE6
              end
              else
                nxt_state.phase = ST_IDLE;                 // RULE5
            end
            default:
              nxt_state.bit_cnt = ZERO4;
          endcase
        end
        else
        begin
          nxt_state.bit_cnt = state_ff.bit_cnt + 4'h1;
          if (state_ff.phase == ST_RD)
          begin
            nxt_state.shift   = {state_ff.shift[6:0], 1'b0};
            nxt_state.sda_low = ~state_ff.shift[6];        // RULE6
          end
        end
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= '{scl_m: 1'b1, sda_m: 1'b1, scl_s: 1'b1, sda_s: 1'b1,
                    scl_d: 1'b1, sda_d: 1'b1, phase: ST_IDLE,
                    bit_cnt: ZERO4, shift: ZERO8, ack_slot: 1'b0,
                    rd_ack: 1'b0, sda_low: 1'b0, ptr: PTR_RESET,
                    wdata: ZERO8, we: 1'b0};
    else
      state_ff <= nxt_state;
  end

  // outputs straight from flops; data line only ever pulled low
  assign link.sda_s_out = 1'b0;
  assign link.sda_s_oe  = state_ff.sda_low;                // RULE3 RULE5
  assign reg_addr       = state_ff.ptr;
  assign reg_wdata      = state_ff.wdata;
  assign reg_we         = state_ff.we;

endmodule : rtc_i2c_slave

/* File: verilog/rtc_i2c_master.sv */
// bus master end: writes pointer and data or reads bytes
`timescale 1ns/100ps
module rtc_i2c_master
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // link
  i2c_link_if.master       link,
  // user command
  input  wire logic        cmd_valid,
  input  wire logic        cmd_read,
  input  wire logic [7:0]  cmd_data,   // pointer or data byte
  input  wire logic        cmd_last,   // stop after this pointer, data or read byte
  output logic             cmd_ready,
  // results
  output logic [7:0]       rsp_data,
  output logic             rsp_valid,
  output logic             rsp_nack
);
  import rtc_port_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0]
  {
    M_IDLE  = 3'b000,
    M_START = 3'b001,
    M_BIT   = 3'b010,
    M_STOP  = 3'b011,
    M_WAIT  = 3'b100
  } mst_e;

  typedef struct packed
  {
    logic       sda_m;
    logic       sda_s;
    mst_e       st;
    logic [7:0] div;
    logic       scl_lo;
    logic       sda_lo;
    logic [1:0] step;     // 0 low-a, 1 low-b, 2 high-a, 3 high-b
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic       reading;  // byte is received
    logic       last;
    logic       addr_ph;
    logic       dir_rd;
    logic       ready;
    logic [7:0] rdata;
    logic       rvalid;
    logic       nack;
  } mst_s;

  mst_s ms_ff;
  mst_s nxt_ms;
  logic tick;

  assign tick = (ms_ff.div == ZERO8);

  // ----------------------------------------
  // next state; quarter-period steps from divider
  // ----------------------------------------
  always_comb
  begin
    nxt_ms        = ms_ff;
    nxt_ms.sda_m  = link.sda;
    nxt_ms.sda_s  = ms_ff.sda_m;
    nxt_ms.rvalid = 1'b0;
    nxt_ms.div    = tick ? HALF_CNT : ms_ff.div - 8'h01;
    case (ms_ff.st)
      M_IDLE:
      begin
        nxt_ms.ready = 1'b1;
        if (cmd_valid & ms_ff.ready)
        begin
          nxt_ms.ready   = 1'b0;
          nxt_ms.dir_rd  = cmd_read;
          nxt_ms.shift   = {DEV_ADDR, cmd_read};
          nxt_ms.step    = 2'd0;
          nxt_ms.addr_ph = 1'b1;
          nxt_ms.st      = M_START;
        end
      end
      M_START:
        if (tick)
        begin
          nxt_ms.step = ms_ff.step + 2'd1;
          // data falls first; clock drops a quarter period later so the
          // first bit never changes together with the clock edge
          if (ms_ff.step == 2'd0)
            nxt_ms.sda_lo = 1'b1;    // RULE16 RULE15
          else
          begin
            nxt_ms.scl_lo  = 1'b1;   // RULE18
            nxt_ms.st      = M_BIT;
            nxt_ms.step    = 2'd0;
            nxt_ms.bit_cnt = ZERO4;
            nxt_ms.reading = 1'b0;
          end
        end
      M_BIT:
        if (tick)
        begin
          nxt_ms.step = ms_ff.step + 2'd1;
          case (ms_ff.step)
            2'd0:
            begin
              nxt_ms.scl_lo = 1'b1;
              // drive only while clock low; RULE6 RULE18
              if (ms_ff.bit_cnt == BIT_ACK)
                nxt_ms.sda_lo = ms_ff.reading & ~ms_ff.last; // RULE4
              else
                nxt_ms.sda_lo = ~ms_ff.reading & ~ms_ff.shift[7];
            end
            2'd1: nxt_ms.scl_lo = 1'b0;
            2'd2:
              if (ms_ff.bit_cnt == BIT_ACK)
              begin
                if (!ms_ff.reading)
                  nxt_ms.nack = ms_ff.sda_s;
              end
              else
                nxt_ms.shift = {ms_ff.shift[6:0], ms_ff.sda_s};
            default:
            begin
              nxt_ms.scl_lo = 1'b1;
              if (ms_ff.bit_cnt == BIT_ACK)   // RULE2
              begin
                nxt_ms.bit_cnt = ZERO4;
                if (ms_ff.reading)
                begin
                  nxt_ms.rdata  = ms_ff.shift;
                  nxt_ms.rvalid = 1'b1;
                end
                nxt_ms.st    = (ms_ff.last | nxt_ms.nack) ? M_STOP
                                                           : M_WAIT;
                nxt_ms.ready = ~(ms_ff.last | nxt_ms.nack);
              end
              else
                nxt_ms.bit_cnt = ms_ff.bit_cnt + 4'h1;
            end
          endcase
        end
      M_WAIT:
      begin
        nxt_ms.sda_lo = 1'b0;
        if (cmd_valid)
        begin
          nxt_ms.ready   = 1'b0;
          nxt_ms.addr_ph = 1'b0;
          nxt_ms.reading = ms_ff.dir_rd;
          nxt_ms.last    = cmd_last;            // RULE11
          nxt_ms.shift   = ms_ff.dir_rd ? ZERO8 : cmd_data;
          nxt_ms.step    = 2'd0;
          nxt_ms.st      = M_BIT;
        end
      end
      M_STOP:
        if (tick)
        begin
          nxt_ms.step = ms_ff.step + 2'd1;
          case (ms_ff.step)
            2'd0: nxt_ms.sda_lo = 1'b1;
            2'd1: nxt_ms.scl_lo = 1'b0;
            default:
            begin
              nxt_ms.sda_lo = 1'b0;   // RULE17
              nxt_ms.last   = 1'b0;
              nxt_ms.nack   = 1'b0;
              nxt_ms.st     = M_IDLE;
            end
          endcase
        end
      default: nxt_ms.st = M_IDLE;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      ms_ff <= '{sda_m: 1'b1, sda_s: 1'b1, st: M_IDLE, div: ZERO8,
                 scl_lo: 1'b0, sda_lo: 1'b0, step: 2'd0, bit_cnt: ZERO4,
                 shift: ZERO8, reading: 1'b0, last: 1'b0, addr_ph: 1'b0,
                 dir_rd: 1'b0, ready: 1'b0, rdata: ZERO8, rvalid: 1'b0,
                 nack: 1'b0};
    else
      ms_ff <= nxt_ms;
  end

  assign link.scl_out   = 1'b0;
  assign link.scl_oe    = ms_ff.scl_lo;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe  = ms_ff.sda_lo;
  assign cmd_ready      = ms_ff.ready;
  assign rsp_data       = ms_ff.rdata;
  assign rsp_valid      = ms_ff.rvalid;
  assign rsp_nack       = ms_ff.nack;

endmodule : rtc_i2c_master

/* File: tb/rtc_link_asserts.sv */
// concurrent checks on the two-wire link between both ends
`timescale 1ns/100ps
module rtc_link_asserts
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link drivers and resolved lines
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_s_out,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  import rtc_port_pkg::*;
  // ------------------------------------------------------------
  // bus tracking
  // ------------------------------------------------------------
  localparam int STOP_WAIT = 1000;
  logic       scl_q, sda_q, live, ack_hi, rw;
  logic [3:0] cnt;
  logic [7:0] bytes, shf;
  wire logic rise     = scl & ~scl_q;
  wire logic fall     = ~scl & scl_q;
  wire logic start_ev = scl & scl_q & sda_q & ~sda;
  wire logic stop_ev  = scl & scl_q & ~sda_q & sda;
  wire logic nack     = rise & (cnt == BIT_ACK) & rw & (bytes != ZERO8)
                        & live & sda;
  wire logic slave_rx = live & (~rw | (bytes == ZERO8));

  // live only while our address was seen; cleared by start, stop, nack
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      {scl_q, sda_q, live, ack_hi, rw} <= 5'h18;
      cnt   <= ZERO4;
      bytes <= ZERO8;
      shf   <= ZERO8;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_ev)
      begin
        cnt   <= ZERO4;
        bytes <= ZERO8;
        live  <= 1'b0;
      end
      else if (stop_ev)
        live <= 1'b0;
      else if (rise)
      begin
        shf    <= {shf[6:0], sda};
        cnt    <= (cnt == BIT_ACK) ? ZERO4 : cnt + 4'h1;
        ack_hi <= (cnt == BIT_ACK);
        if (cnt == BIT_LAST && bytes == ZERO8)
        begin
          live <= (shf[6:0] == DEV_ADDR);
          rw   <= sda;
        end
        if (nack)
          live <= 1'b0;
      end
      else if (fall)
      begin
        ack_hi <= 1'b0;
        if (ack_hi)
          bytes <= bytes + 8'h01;
      end
    end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence ack_slot;
    rise && cnt == BIT_ACK;
  endsequence
  sequence stop_seq;
    ##[0:STOP_WAIT] stop_ev;
  endsequence

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  addr_ack_a: assert property (
    ack_slot ##0 (bytes == ZERO8 && live) |-> sda_s_oe)
    else $error("address byte not acknowledged");
  wr_ack_a: assert property (
    ack_slot ##0 (bytes != ZERO8 && !rw && live) |-> sda_s_oe)
    else $error("written byte not acknowledged");
  ack_hold_a: assert property (
    ack_hi && slave_rx |-> sda_s_oe && !sda)
    else $error("acknowledge not held low over clock high");
  quiet_idle_a: assert property (
    !live |-> !sda_s_oe)
    else $error("data driven while not addressed");
  nack_release_a: assert property (
    nack |=> (!sda_s_oe throughout stop_seq))
    else $error("data not released after not-acknowledge");
  data_stable_a: assert property (
    scl && scl_q |-> $stable(sda_s_oe))
    else $error("port changed data while clock high");
  rd_drive_a: assert property (
    rise && cnt != BIT_ACK && rw && bytes != ZERO8 && live
    |-> !sda_m_oe && (sda == !sda_s_oe))
    else $error("read bit not driven by the port");
  stop_free_a: assert property (
    stop_ev |=> (!sda_s_oe) [*8])
    else $error("data driven after stop");
endmodule : rtc_link_asserts

/* File: tb/tb.sv */
// self-checking bench: master and register port on one link
`timescale 1ns/100ps
module tb;
  import rtc_port_pkg::*;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic       ref_clk, rst_b, cmd_valid, cmd_read, cmd_last, cmd_ready;
  logic       rsp_valid, rsp_nack, reg_we, nack_seen;
  logic [7:0] cmd_data, rsp_data, reg_addr, reg_wdata, reg_rdata, exp_ptr;
  logic [7:0] mem     [256];
  logic [7:0] exp_mem [256];
  int         failures, checks;

  i2c_link_if link ();
  rtc_i2c_master u_rtc_i2c_master (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(link), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack));
  rtc_i2c_slave u_rtc_i2c_slave (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_rdata(reg_rdata));
  rtc_link_asserts u_rtc_link_asserts (.ref_clk(ref_clk), .rst_b(rst_b),
    .scl_out(link.scl_out), .scl_oe(link.scl_oe),
    .sda_m_out(link.sda_m_out), .sda_m_oe(link.sda_m_oe),
    .sda_s_out(link.sda_s_out), .sda_s_oe(link.sda_s_oe),
    .scl(link.scl), .sda(link.sda));

  // register space; pointer already advanced when the write strobe shows
  assign reg_rdata = mem[reg_addr];
  always @(posedge ref_clk)
    if (reg_we)
      mem[reg_addr - 8'h01] <= reg_wdata;

  // sticky record of a refused byte; the master drops its flag at stop
  always @(posedge ref_clk)
    if (!rst_b)
      nack_seen <= 1'b0;
    else if (rsp_nack !== 1'b0)
      nack_seen <= 1'b1;

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] init_val(input int i);
    return 8'(i) ^ 8'ha5;
  endfunction : init_val

  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task check8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  // bounded wait; a byte takes about 3600 cycles
  task wait_ready(input logic lvl);
    int n;
    for (n = 0; n < 8000; n++)
    begin
      @(posedge ref_clk);
      #1;
      if (cmd_ready === lvl)
        break;
    end
    if (n == 8000)
    begin
      failures++;
      give_verdict;
    end
  endtask : wait_ready

  task send(input logic rd, input logic [7:0] d, input logic last);
    wait_ready(1'b1);
    check8({7'h00, nack_seen}, 8'h00);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_data  = d;
    cmd_last  = last;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    wait_ready(1'b0);
  endtask : send

  task get_byte(input logic last);
    int n;
    send(1'b1, 8'h00, last);
    for (n = 0; n < 8000 && rsp_valid !== 1'b1; n++)
      @(posedge ref_clk) #1;
    if (n == 8000)
    begin
      failures++;
      give_verdict;
    end
    check8(rsp_data, exp_mem[exp_ptr]);
    exp_ptr++;
  endtask : get_byte

  // pointer byte then n random data bytes
  task put_ptr(input logic [7:0] p, input int n);
    int         i;
    logic [7:0] d;
    send(1'b0, 8'h00, 1'b0);
    send(1'b0, p, n == 0);
    exp_ptr = p;
    for (i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      send(1'b0, d, i == n - 1);
      exp_mem[exp_ptr] = d;
      exp_ptr++;
    end
    wait_ready(1'b1);
    check8(reg_addr, exp_ptr);
  endtask : put_ptr

  task read_run(input int n);
    int i;
    send(1'b1, 8'h00, 1'b0);
    for (i = 0; i < n; i++)
      get_byte(i == n - 1);
    wait_ready(1'b1);
    check8(reg_addr, exp_ptr);
  endtask : read_run

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int i;
    void'($urandom(98033));
    {rst_b, cmd_valid, cmd_read, cmd_last} = 4'h0;
    cmd_data = 8'h00;
    failures = 0;
    checks   = 0;
    exp_ptr  = PTR_RESET;
    for (i = 0; i < 256; i++)
    begin
      mem[i]     = init_val(i);
      exp_mem[i] = init_val(i);
    end
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    read_run(1);
    put_ptr(8'hfe, 3);
    read_run(2);
    put_ptr(8'hfe, 0);
    read_run(3);
    put_ptr(8'($urandom), 0);
    read_run(1);
    give_verdict;
  end
endmodule : tb
